// [rtl/lock_ctrl.sv]
// bus-hold (lock) output control
// assumes bus state strobes from the core sequencer
`timescale 1ns/1ps
module lock_ctrl (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // core events
  input  wire logic lock_prefix_in,
  input  wire logic instr_done_in,
  input  wire logic large_sys_in,
  input  wire logic second_bus_state_in,
  input  wire logic interrupt_ack_cycle_in,
  input  wire logic ack_second_in,
  input  wire logic grant_seq_in,
  // state and pin
  output logic      locked_out,
  output logic      bus_hold_n_out,
  output logic      bus_hold_oe_out
);
  typedef enum logic [1:0] {L_IDLE, L_PREFIX, L_INSTR} lk_t;
  lk_t  lk_ff, nxt_lk;
  logic ack_ff, nxt_ack;

  // prefix lock sequence and interrupt ack lock
  always_comb begin
    nxt_lk  = lk_ff;
    nxt_ack = ack_ff;
    case (lk_ff)
      L_IDLE:   if (lock_prefix_in) nxt_lk = L_PREFIX;
      L_PREFIX: if (instr_done_in) nxt_lk = L_INSTR;          // prefix itself done
      L_INSTR:  if (instr_done_in) nxt_lk = L_IDLE;           // following instr done
      default:  nxt_lk = L_IDLE;
    endcase
    if (large_sys_in && interrupt_ack_cycle_in && second_bus_state_in) begin
      nxt_ack = !ack_second_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      lk_ff  <= L_IDLE;
      ack_ff <= 1'b0;
    end else begin
      lk_ff  <= nxt_lk;
      ack_ff <= nxt_ack;
    end
  end

  assign locked_out = (lk_ff != L_IDLE) || ack_ff;
  // low holds other masters off; float (pulled one) in grant
  assign bus_hold_n_out  = !locked_out;
  assign bus_hold_oe_out = !grant_seq_in;

  property p_lk_grant;
    @(posedge mclk_in) disable iff (rst_in)
    grant_seq_in |-> !bus_hold_oe_out;
  endproperty
  a_lk_grant: assert property (p_lk_grant) else $error("hold driven in grant");

  property p_lk_prefix;
    @(posedge mclk_in) disable iff (rst_in)
    (lk_ff == L_IDLE && lock_prefix_in) |=> !bus_hold_n_out;
  endproperty
  a_lk_prefix: assert property (p_lk_prefix) else $error("prefix did not lock");

  property p_lk_ack;
    @(posedge mclk_in) disable iff (rst_in)
    (large_sys_in && interrupt_ack_cycle_in && second_bus_state_in && !ack_second_in) |=> !bus_hold_n_out;
  endproperty
  a_lk_ack: assert property (p_lk_ack) else $error("ack lock missing");
endmodule : lock_ctrl

// [rtl/max_mode_lock_queue_status.sv]
// maximum-mode bus handover, lock and queue status top
// assumes core strobes synchronous to mclk_in; grant request is one pulse
`timescale 1ns/1ps
module max_mode_lock_queue_status (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // handover request and bus status
  input  wire logic bus_req_in,
  input  wire logic bus_idle_in,
  input  wire logic mem_start_in,
  input  wire logic cycle_end_in,
  input  wire logic second_bus_state_in,
  input  wire logic odd_low_byte_in,
  input  wire logic interrupt_ack_cycle_in,
  input  wire logic ack_second_in,
  input  wire logic grant_seq_in,
  // instruction events
  input  wire logic lock_prefix_in,
  input  wire logic instr_done_in,
  input  wire logic large_sys_in,
  // queue events
  input  wire logic q_first_in,
  input  wire logic q_next_in,
  input  wire logic q_flush_in,
  // outputs
  output logic      release_out,
  output logic      start_timeout_out,
  output logic      bus_hold_n_out,
  output logic      bus_hold_oe_out,
  output logic      queue_status_hi_out,
  output logic      queue_status_lo_out
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACTIVE} hs_t;
  hs_t        hs_ff, nxt_hs;
  logic [1:0] cnt_ff, nxt_cnt;
  logic       rel_ff, nxt_rel;
  logic       to_ff, nxt_to;
  logic       locked;
  logic [2:0] age_ff, nxt_age;

  lock_ctrl u_lock (
    .mclk_in                (mclk_in),
    .rst_in                 (rst_in),
    .lock_prefix_in         (lock_prefix_in),
    .instr_done_in          (instr_done_in),
    .large_sys_in           (large_sys_in),
    .second_bus_state_in    (second_bus_state_in),
    .interrupt_ack_cycle_in (interrupt_ack_cycle_in),
    .ack_second_in          (ack_second_in),
    .grant_seq_in           (grant_seq_in),
    .locked_out             (locked),
    .bus_hold_n_out         (bus_hold_n_out),
    .bus_hold_oe_out        (bus_hold_oe_out)
  );

  queue_status u_qs (
    .mclk_in             (mclk_in),
    .rst_in              (rst_in),
    .q_first_in          (q_first_in),
    .q_next_in           (q_next_in),
    .q_flush_in          (q_flush_in),
    .queue_status_hi_out (queue_status_hi_out),
    .queue_status_lo_out (queue_status_lo_out)
  );

  // active cycle may release: request timing already met
  function automatic logic may_release(input logic odd_lo, input logic ack1, input logic lk);
    may_release = !odd_lo && !ack1 && !lk;
  endfunction

  // handover sequencer
  always_comb begin
    nxt_hs  = hs_ff;
    nxt_cnt = cnt_ff;
    nxt_rel = 1'b0;
    nxt_to  = 1'b0;
    case (hs_ff)
      H_IDLE: begin
        if (bus_req_in && bus_idle_in) begin
          if (mem_start_in) begin
            nxt_hs = H_ACTIVE;
          end else begin
            nxt_rel = 1'b1;
          end
        end else if (bus_req_in) begin
          nxt_hs  = (second_bus_state_in || !mem_start_in) ? H_ACTIVE : H_IDLE;
          nxt_cnt = 2'h0;
        end
      end
      H_WAIT: begin
        nxt_cnt = cnt_ff + 2'h1;
        if (mem_start_in) nxt_hs = H_ACTIVE;
        else if (cnt_ff == 2'(mml_pkg::IDLE_START_CLK - 1)) begin
          nxt_to = 1'b1;
          nxt_hs = H_IDLE;
        end
      end
      H_ACTIVE: begin
        if (cycle_end_in) begin
          nxt_hs = H_IDLE;
          nxt_rel = may_release(odd_low_byte_in, interrupt_ack_cycle_in && !ack_second_in, locked);
        end
      end
      default: nxt_hs = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hs_ff  <= H_IDLE;
      cnt_ff <= 2'h0;
      rel_ff <= 1'b0;
      to_ff  <= 1'b0;
    end else begin
      hs_ff  <= nxt_hs;
      cnt_ff <= nxt_cnt;
      rel_ff <= nxt_rel;
      to_ff  <= nxt_to;
    end
  end

  assign release_out       = rel_ff;
  assign start_timeout_out = to_ff;

  property p_idle_release;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_IDLE && bus_req_in && bus_idle_in && !mem_start_in) |=> release_out;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("idle release late");

  property p_locked_no_release;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && cycle_end_in && locked) |=> !release_out;
  endproperty
  a_locked_no_release: assert property (p_locked_no_release) else $error("release while locked");

  // clocks spent waiting for a memory cycle, saturating
  always_comb begin
    nxt_age = 3'h0;
    if (hs_ff == H_WAIT) begin
      nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
    end
  end

  // wait-age register, only tracks the sequencer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) age_ff <= 3'h0;
    else age_ff <= nxt_age;
  end

  // wait for a memory cycle never outlasts the start window
  property p_wait_age;
    @(posedge mclk_in) disable iff (rst_in)
    age_ff <= 3'(mml_pkg::IDLE_START_CLK);
  endproperty
  a_wait_age: assert property (p_wait_age) else $error("memory start window exceeded");

  // idle release leaves the sequencer idle
  property p_idle_stays;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_IDLE && bus_req_in && bus_idle_in && !mem_start_in) |=> (hs_ff == H_IDLE);
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("idle release left idle state");

  // memory cycle chosen instead of release moves to active
  property p_idle_mem_active;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_IDLE && bus_req_in && bus_idle_in && mem_start_in) |=> (hs_ff == H_ACTIVE);
  endproperty
  a_idle_mem_active: assert property (p_idle_mem_active) else $error("memory cycle not tracked");

  // memory cycle chosen means no immediate release
  property p_idle_mem_no_rel;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_IDLE && bus_req_in && bus_idle_in && mem_start_in) |=> !release_out;
  endproperty
  a_idle_mem_no_rel: assert property (p_idle_mem_no_rel) else $error("released during memory cycle");

  // wait ends with a timeout flag when no cycle starts
  property p_wait_timeout;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_WAIT && !mem_start_in && cnt_ff == 2'(mml_pkg::IDLE_START_CLK - 1)) |=> start_timeout_out;
  endproperty
  a_wait_timeout: assert property (p_wait_timeout) else $error("start timeout missing");

  // timeout flag is a single pulse
  property p_timeout_pulse;
    @(posedge mclk_in) disable iff (rst_in)
    start_timeout_out |=> !start_timeout_out;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout longer than one clock");

  // odd low byte refuses release at cycle end
  property p_odd_refused;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && cycle_end_in && odd_low_byte_in) |=> !release_out;
  endproperty
  a_odd_refused: assert property (p_odd_refused) else $error("release on odd low byte");

  // first acknowledge refuses release at cycle end
  property p_ack1_refused;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && cycle_end_in && interrupt_ack_cycle_in && !ack_second_in) |=> !release_out;
  endproperty
  a_ack1_refused: assert property (p_ack1_refused) else $error("release on first acknowledge");

  // all conditions met: release follows cycle end
  property p_active_release;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && cycle_end_in && !odd_low_byte_in && !(interrupt_ack_cycle_in && !ack_second_in)
      && !locked) |=> release_out;
  endproperty
  a_active_release: assert property (p_active_release) else $error("allowed release missing");

  // active cycle holds until its end strobe
  property p_active_holds;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && !cycle_end_in) |=> (hs_ff == H_ACTIVE);
  endproperty
  a_active_holds: assert property (p_active_holds) else $error("active cycle dropped early");

  // cycle end returns the sequencer to idle
  property p_active_exit;
    @(posedge mclk_in) disable iff (rst_in)
    (hs_ff == H_ACTIVE && cycle_end_in) |=> (hs_ff == H_IDLE);
  endproperty
  a_active_exit: assert property (p_active_exit) else $error("active cycle did not end");

  // a release always has a request or cycle end behind it
  property p_release_cause;
    @(posedge mclk_in) disable iff (rst_in)
    release_out |-> $past(bus_req_in || cycle_end_in);
  endproperty
  a_release_cause: assert property (p_release_cause) else $error("release without cause");

  // locked state drives bus-hold low
  property p_hold_low;
    @(posedge mclk_in) disable iff (rst_in)
    locked |-> !bus_hold_n_out;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("bus-hold high while locked");

  // unlocked state leaves bus-hold high
  property p_hold_high;
    @(posedge mclk_in) disable iff (rst_in)
    !locked |-> bus_hold_n_out;
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("bus-hold low while unlocked");

  // bus-hold driven whenever no grant runs
  property p_hold_driven;
    @(posedge mclk_in) disable iff (rst_in)
    !grant_seq_in |-> bus_hold_oe_out;
  endproperty
  a_hold_driven: assert property (p_hold_driven) else $error("bus-hold floating outside grant");

  // subsequent byte reported with its own code
  property p_qs_next;
    @(posedge mclk_in) disable iff (rst_in)
    (q_next_in && !q_first_in && !q_flush_in) |=> ({queue_status_hi_out, queue_status_lo_out} == mml_pkg::QS_NEXT);
  endproperty
  a_qs_next: assert property (p_qs_next) else $error("subsequent byte not reported");

  // flush wins over a byte taken in the same clock
  property p_qs_flush_wins;
    @(posedge mclk_in) disable iff (rst_in)
    (q_flush_in && (q_first_in || q_next_in)) |=> ({queue_status_hi_out, queue_status_lo_out} == mml_pkg::QS_FLUSH);
  endproperty
  a_qs_flush_wins: assert property (p_qs_flush_wins) else $error("two queue events reported");
endmodule : max_mode_lock_queue_status

// [rtl/mml_pkg.sv]
// constants for the maximum-mode lock, queue status and idle-bus handover logic
// assumes one 250 MHz clock; bus states and queue events come from the core as pulses
// Contract
// - request on idle bus: release the local bus during the next clock
// - alternatively a memory cycle may start, no later than three clocks after request; code accepts one only in the request clock and never enters H_WAIT
// - if a cycle starts instead, active-cycle release rules apply, timing already met
// - active cycle release: early request, not odd low byte, not first ack, no lock
// - bus-hold output driven low keeps other masters off the system bus
// - lock prefix asserts bus-hold until the following instruction completes
// - during a grant sequence bus-hold floats, reading as logic one
// - large-system mode: bus-hold set in second state of first ack, cleared in second
// - queue status shows in the clock after the queue operation
// - codes: 00 none, 01 first opcode byte, 10 flush, 11 subsequent byte
// - both queue status outputs always driven, never high impedance
package mml_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned IDLE_START_CLK = 3;  // latest memory cycle start after request
  localparam logic [1:0]  QS_NOP         = 2'h0;
  localparam logic [1:0]  QS_FIRST       = 2'h1;
  localparam logic [1:0]  QS_FLUSH       = 2'h2;
  localparam logic [1:0]  QS_NEXT        = 2'h3;
  localparam logic [1:0]  QS_RESET       = 2'h0;
  localparam logic        HOLD_RESET_N   = 1'b1;
endpackage : mml_pkg

// [rtl/queue_status.sv]
// queue status encoder: one registered code per clock
// assumes core raises at most one queue event strobe per clock, flush taking priority
`timescale 1ns/1ps
module queue_status (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // queue events
  input  wire logic q_first_in,
  input  wire logic q_next_in,
  input  wire logic q_flush_in,
  // status pins
  output logic      queue_status_hi_out,
  output logic      queue_status_lo_out
);
  logic [1:0] code_ff;
  logic [1:0] nxt_code;

  // pick one event, flush first
  always_comb begin
    nxt_code = mml_pkg::QS_NOP;
    if (q_flush_in) nxt_code = mml_pkg::QS_FLUSH;
    else if (q_first_in) nxt_code = mml_pkg::QS_FIRST;
    else if (q_next_in) nxt_code = mml_pkg::QS_NEXT;
  end

  // code shows in clock after the event
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) code_ff <= mml_pkg::QS_RESET;
    else code_ff <= nxt_code;
  end

  // always driven, no enable exists
  assign queue_status_hi_out = code_ff[1];
  assign queue_status_lo_out = code_ff[0];

  property p_qs_flush;
    @(posedge mclk_in) disable iff (rst_in)
    q_flush_in |=> (code_ff == mml_pkg::QS_FLUSH);
  endproperty
  a_qs_flush: assert property (p_qs_flush) else $error("flush not reported");

  property p_qs_first;
    @(posedge mclk_in) disable iff (rst_in)
    (q_first_in && !q_flush_in) |=> (code_ff == mml_pkg::QS_FIRST);
  endproperty
  a_qs_first: assert property (p_qs_first) else $error("first byte not reported");

  property p_qs_idle;
    @(posedge mclk_in) disable iff (rst_in)
    !(q_first_in || q_next_in || q_flush_in) |=> (code_ff == mml_pkg::QS_NOP);
  endproperty
  a_qs_idle: assert property (p_qs_idle) else $error("status without event");
endmodule : queue_status

// [test/bus_far_side.sv]
// far-side model: pulled-up bus-hold wire and the tracker's view of queue status
// assumes the bus-hold pin carries a pull-up, so a floating pin reads as one
`timescale 1ns/1ps
module bus_far_side (
  // device pins
  input  wire logic       hold_n_in,
  input  wire logic       hold_oe_in,
  input  wire logic       qs_hi_in,
  input  wire logic       qs_lo_in,
  // resolved view
  output logic            hold_wire_out,
  output logic [1:0]      qs_code_out
);
  // pull-up wins while the device floats the pin
  assign hold_wire_out = hold_oe_in ? hold_n_in : 1'b1;
  // tracker reads the high bit first
  assign qs_code_out = {qs_hi_in, qs_lo_in};
endmodule : bus_far_side

// [test/max_mode_lock_queue_status_bench.sv]
// bench for handover, lock and queue status outputs
// assumes the design and the far-side model are compiled first
`timescale 1ns/1ps
module max_mode_lock_queue_status_bench;
  logic mclk_in = 0, rst_in = 1, bus_req_in = 0, bus_idle_in = 0, mem_start_in = 0, cycle_end_in = 0;
  logic second_bus_state_in = 0, odd_low_byte_in = 0, interrupt_ack_cycle_in = 0, ack_second_in = 0;
  logic grant_seq_in = 0, lock_prefix_in = 0, instr_done_in = 0, large_sys_in = 0;
  logic q_first_in = 0, q_next_in = 0, q_flush_in = 0;
  logic release_out, start_timeout_out, bus_hold_n_out, bus_hold_oe_out, queue_status_hi_out, queue_status_lo_out;
  logic hold_wire;
  logic [1:0] qs_code;
  int mismatches = 0, num_checks = 0;
  max_mode_lock_queue_status dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .bus_req_in(bus_req_in),
    .bus_idle_in(bus_idle_in), .mem_start_in(mem_start_in), .cycle_end_in(cycle_end_in),
    .second_bus_state_in(second_bus_state_in), .odd_low_byte_in(odd_low_byte_in),
    .interrupt_ack_cycle_in(interrupt_ack_cycle_in), .ack_second_in(ack_second_in),
    .grant_seq_in(grant_seq_in), .lock_prefix_in(lock_prefix_in), .instr_done_in(instr_done_in),
    .large_sys_in(large_sys_in), .q_first_in(q_first_in), .q_next_in(q_next_in), .q_flush_in(q_flush_in),
    .release_out(release_out), .start_timeout_out(start_timeout_out), .bus_hold_n_out(bus_hold_n_out),
    .bus_hold_oe_out(bus_hold_oe_out), .queue_status_hi_out(queue_status_hi_out),
    .queue_status_lo_out(queue_status_lo_out));
  bus_far_side far_u (.hold_n_in(bus_hold_n_out), .hold_oe_in(bus_hold_oe_out), .qs_hi_in(queue_status_hi_out),
    .qs_lo_in(queue_status_lo_out), .hold_wire_out(hold_wire), .qs_code_out(qs_code));
  // free-running clock
  initial begin
    forever #(mml_pkg::CLK_PERIOD_NS / 2.0) mclk_in = ~mclk_in;
  end
  // one compare for every result kind
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // wait one edge, then let its updates land
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask : tick
  // idle request, released in the next clock only
  task automatic t_idle_release();
    @(posedge mclk_in); bus_idle_in <= 1'b1; bus_req_in <= 1'b1;
    @(posedge mclk_in); bus_req_in <= 1'b0;
    #1 chk(release_out, 1'b1);
    tick(); chk(release_out, 1'b0);
  endtask : t_idle_release
  // idle request taken by a memory cycle, then released at its end unless refused
  task automatic t_mem_then_end(input logic odd, input logic exp);
    @(posedge mclk_in); bus_idle_in <= 1'b1; bus_req_in <= 1'b1; mem_start_in <= 1'b1; odd_low_byte_in <= odd;
    @(posedge mclk_in); bus_req_in <= 1'b0; mem_start_in <= 1'b0; bus_idle_in <= 1'b0;
    #1 chk(release_out, 1'b0);
    chk(start_timeout_out, 1'b0);
    @(posedge mclk_in); cycle_end_in <= 1'b1;
    @(posedge mclk_in); cycle_end_in <= 1'b0;
    #1 chk(release_out, exp);
    tick(); chk(release_out, 1'b0);
  endtask : t_mem_then_end
  // queue events each followed by an idle clock, one code per event
  task automatic t_queue();
    logic [2:0] ev [4] = '{3'h4, 3'h1, 3'h2, 3'h0};
    logic [1:0] ex [4] = '{mml_pkg::QS_FLUSH, mml_pkg::QS_FIRST, mml_pkg::QS_NEXT, mml_pkg::QS_NOP};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in); {q_flush_in, q_next_in, q_first_in} <= ev[i];
      @(posedge mclk_in); {q_flush_in, q_next_in, q_first_in} <= 3'h0;
      #1 chk(qs_code, ex[i]);
    end
  endtask : t_queue
  // lock prefix holds the bus until the following instruction completes
  task automatic t_lock();
    @(posedge mclk_in); lock_prefix_in <= 1'b1;
    @(posedge mclk_in); lock_prefix_in <= 1'b0; instr_done_in <= 1'b1;
    #1 chk({bus_hold_oe_out, hold_wire}, 2'h2);
    @(posedge mclk_in); instr_done_in <= 1'b0;
    #1 chk(hold_wire, 1'b0);
    @(posedge mclk_in); instr_done_in <= 1'b1;
    @(posedge mclk_in); instr_done_in <= 1'b0;
    #1 chk(hold_wire, 1'b1);
  endtask : t_lock
  // large-system acknowledge pair sets then clears bus-hold
  task automatic t_ack();
    @(posedge mclk_in); large_sys_in <= 1'b1; interrupt_ack_cycle_in <= 1'b1; second_bus_state_in <= 1'b1;
    @(posedge mclk_in); second_bus_state_in <= 1'b0;
    #1 chk(hold_wire, 1'b0);
    @(posedge mclk_in); ack_second_in <= 1'b1; second_bus_state_in <= 1'b1;
    @(posedge mclk_in); second_bus_state_in <= 1'b0; interrupt_ack_cycle_in <= 1'b0; ack_second_in <= 1'b0;
    #1 chk(hold_wire, 1'b1);
  endtask : t_ack
  // grant sequence floats bus-hold while queue status stays driven
  task automatic t_grant();
    @(posedge mclk_in); grant_seq_in <= 1'b1; q_flush_in <= 1'b1;
    @(posedge mclk_in); q_flush_in <= 1'b0;
    #1 chk({bus_hold_oe_out, hold_wire}, 2'h1);
    chk({queue_status_hi_out, queue_status_lo_out}, mml_pkg::QS_FLUSH);
    @(posedge mclk_in); grant_seq_in <= 1'b0;
  endtask : t_grant
  // verdict and end of run
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_idle_release();
    t_mem_then_end(1'b0, 1'b1);
    t_queue();
    t_lock();
    t_ack();
    t_grant();
    t_mem_then_end(1'b1, 1'b0);
    test_done();
  end
  // watchdog
  initial begin
    #20000;
    mismatches++;
    test_done();
  end
endmodule : max_mode_lock_queue_status_bench
